// ---- src/flash_status2_config1_regs.sv ----
// Status-two and non-volatile config-one registers behind a serial link
//
// Contract
// - Status two readable only, opcodes 07h/65h.
// - Status two resets zero, bits 7-3 zero.
// - Erase-result bit follows sector erase status.
// - Erase-suspended flag mirrors erase suspend.
// - Program-suspended flag mirrors program suspend.
// - Config one written by 01h or 71h.
// - Direction bit one anchors protection at zero.
// - Set one-time bits ignore zero writes silently.
// - Source zero: write-registers programs non-volatile protection.
// - Source set programs 111, reset loads it.
// - Source one: write-registers updates volatile protection only.
// - Placement bit puts parameter block top/bottom.
// - Uniform layout: placement bit has no effect.
// - Direction and placement programmed independently.
// - Four-lane default loads volatile four-lane bit.
// - Protocol programming also sets four-lane default.
// - Volatile protocol bit blocks clearing four-lane default.
// - Lock default loads lock, not host programmable.
// - Bits 7, 6, 4 reserved zero; factory zero.
// - One-time bits and protection ship cleared.
module flash_status2_config1_regs #(
	parameter int NV_CYCLES = flash_regs_pkg::NV_WRITE_CYCLES
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic sck,
	input wire logic cs_n,
	input wire logic si,
	output logic so,
	output logic so_oe_n,
	input wire flash_regs_pkg::array_status_t array_status,
	input wire logic write_enable,
	input wire logic four_wire_protocol_v,
	input wire logic four_wire_protocol_nv_set,
	input wire logic uniform_sectors,
	input wire logic soft_reset,
	output logic [2:0] block_protect_bits,
	output logic [2:0] block_protect_nonvolatile_bits,
	output logic protect_from_bottom,
	output logic param_block_at_top,
	output logic four_lane_mode,
	output logic protect_lock,
	output logic nv_write_busy,
	output logic write_done
);

	////////////////////////////////////////////////////////////////////////
	// Link domain: capture frame bytes, shift read data out

	logic [2:0] bit_cnt_ff;
	logic [2:0] byte_cnt_ff;
	logic [6:0] in_sh_ff;
	logic [7:0] frame_ff [flash_regs_pkg::FRAME_BYTES];
	logic [7:0] out_sh_ff;
	logic oe_n_ff;
	flash_regs_pkg::reg_image_t image_ff;
	logic [2:0] len_ff;
	logic whole_ff;

	function automatic logic [7:0] select_reg(
		input logic [23:0] addr,
		input flash_regs_pkg::reg_image_t img
	);
		logic [7:0] val;
		val = flash_regs_pkg::RESET_BYTE;
		if (addr == flash_regs_pkg::ADDR_STATUS_TWO_V) begin
			val = img.status_two;
		end else if (addr == flash_regs_pkg::ADDR_CONFIG_ONE_NV) begin
			val = img.config_one_nv;
		end else if (addr == flash_regs_pkg::ADDR_CONFIG_ONE_V) begin
			val = img.config_one_v;
		end
		return val;
	endfunction

	// Counters restart at every frame; sck may stop between frames
	always_ff @(posedge sck or posedge cs_n) begin
		if (cs_n) begin
			bit_cnt_ff <= 3'h0;
			byte_cnt_ff <= 3'h0;
		end else begin
			bit_cnt_ff <= bit_cnt_ff + 3'h1;
			if (bit_cnt_ff == 3'h7 && byte_cnt_ff != flash_regs_pkg::CNT_MAX) begin
				byte_cnt_ff <= byte_cnt_ff + 3'h1;
			end
		end
	end

	always_ff @(posedge sck) begin
		in_sh_ff <= {in_sh_ff[5:0], si};
	end

	// Length kept past cs_n rise, counters clear too early for clk side
	// Limitation: a frame with no sck edges reuses the last length
	always_ff @(posedge sck) begin
		whole_ff <= bit_cnt_ff == 3'h7;
		if (bit_cnt_ff == 3'h7) begin
			if (byte_cnt_ff == flash_regs_pkg::CNT_MAX) begin
				len_ff <= flash_regs_pkg::CNT_MAX;
			end else begin
				len_ff <= byte_cnt_ff + 3'h1;
			end
		end
	end

	// Bytes stay frozen after cs_n rises until the next frame
	always_ff @(posedge sck) begin
		if (!cs_n && bit_cnt_ff == 3'h7
			&& byte_cnt_ff < 3'(flash_regs_pkg::FRAME_BYTES)) begin
			frame_ff[byte_cnt_ff] <= {in_sh_ff, si};
		end
	end

	logic [7:0] link_op;
	logic [23:0] link_addr;
	assign link_op = frame_ff[flash_regs_pkg::BYTE_OPCODE];
	assign link_addr = {frame_ff[flash_regs_pkg::BYTE_ADDR_HI],
		frame_ff[flash_regs_pkg::BYTE_ADDR_MID],
		frame_ff[flash_regs_pkg::BYTE_ADDR_LO]};

	// Read data changes on falling sck, host samples on rising
	always_ff @(negedge sck or posedge cs_n) begin
		if (cs_n) begin
			out_sh_ff <= flash_regs_pkg::RESET_BYTE;
			oe_n_ff <= 1'b1;
		end else if (bit_cnt_ff == 3'h0) begin
			if (link_op == flash_regs_pkg::OP_READ_STATUS_TWO
				&& byte_cnt_ff >= flash_regs_pkg::CNT_READ_STATUS_TWO_CMD_DATA) begin
				out_sh_ff <= image_ff.status_two;
				oe_n_ff <= 1'b0;
			end else if (link_op == flash_regs_pkg::OP_READ_ANY_REG
				&& byte_cnt_ff >= flash_regs_pkg::CNT_READ_ANY_REGISTER_CMD_DATA) begin
				out_sh_ff <= select_reg(link_addr, image_ff);
				oe_n_ff <= 1'b0;
			end else begin
				out_sh_ff <= {out_sh_ff[6:0], 1'b0};
			end
		end else begin
			out_sh_ff <= {out_sh_ff[6:0], 1'b0};
		end
	end

	assign so = out_sh_ff[7];
	assign so_oe_n = oe_n_ff;

	////////////////////////////////////////////////////////////////////////
	// Frame end crossing into clk domain

	logic cs_meta_ff;
	logic cs_sync_ff;
	logic cs_prev_ff;
	logic frame_end;

	always_ff @(posedge clk) begin
		if (rst) begin
			cs_meta_ff <= 1'b1;
			cs_sync_ff <= 1'b1;
			cs_prev_ff <= 1'b1;
		end else begin
			cs_meta_ff <= cs_n;
			cs_sync_ff <= cs_meta_ff;
			cs_prev_ff <= cs_sync_ff;
		end
	end

	// Frame bytes are stable once cs_n has been seen high
	assign frame_end = cs_sync_ff && !cs_prev_ff;

	////////////////////////////////////////////////////////////////////////
	// Status two

	logic erase_result_ff;

	always_ff @(posedge clk) begin
		if (rst) begin
			erase_result_ff <= 1'b0;
		end else if (array_status.erase_status_strobe) begin
			// result of last sector erase status
			erase_result_ff <= array_status.erase_status_done;
		end
	end

	logic [7:0] status_two;
	always_comb begin
		status_two = flash_regs_pkg::RESET_BYTE;
		status_two[flash_regs_pkg::ST2_ERASE_RESULT] = erase_result_ff;
		status_two[flash_regs_pkg::ST2_ERASE_SUSP] =
			array_status.erase_suspended;
		status_two[flash_regs_pkg::ST2_PROG_SUSP] =
			array_status.program_suspended;
	end

	////////////////////////////////////////////////////////////////////////
	// Decode completed write frames

	logic wrr_one;
	logic wrr_two;
	logic write_any_register_cmd;
	logic wr_cf1_nv;
	logic wr_cf1_v;
	logic wr_bp;
	logic [7:0] cf1_data;
	logic [2:0] bp_data;
	logic write_ok;

	assign write_ok = frame_end && write_enable && whole_ff;
	assign wrr_one = link_op == flash_regs_pkg::OP_WRITE_REGISTERS
		&& len_ff == flash_regs_pkg::CNT_WRR_ONE;
	assign wrr_two = link_op == flash_regs_pkg::OP_WRITE_REGISTERS
		&& len_ff == flash_regs_pkg::CNT_WRR_TWO;
	assign write_any_register_cmd = link_op == flash_regs_pkg::OP_WRITE_ANY_REG
		&& len_ff == flash_regs_pkg::CNT_WRITE_ANY_REGISTER_CMD;
	assign wr_bp = write_ok && (wrr_one || wrr_two);
	assign wr_cf1_nv = write_ok && (wrr_two || (write_any_register_cmd
		&& link_addr == flash_regs_pkg::ADDR_CONFIG_ONE_NV));
	assign wr_cf1_v = write_ok && write_any_register_cmd
		&& link_addr == flash_regs_pkg::ADDR_CONFIG_ONE_V;
	assign cf1_data = write_any_register_cmd ? frame_ff[flash_regs_pkg::BYTE_WRITE_ANY_REGISTER_CMD_DATA]
		: frame_ff[flash_regs_pkg::BYTE_ADDR_MID];
	assign bp_data = frame_ff[flash_regs_pkg::BYTE_ADDR_HI]
		[flash_regs_pkg::ST1_BP_MSB:flash_regs_pkg::ST1_BP_LSB];

	////////////////////////////////////////////////////////////////////////
	// Non-volatile write sequencer

	flash_regs_pkg::wr_state_t state_ff;
	flash_regs_pkg::wr_state_t nxt_state;
	logic [15:0] nv_cnt_ff;
	logic nv_start;
	logic nv_done;

	logic prot_dir_ff;
	logic prot_src_ff;
	logic param_place_ff;
	logic four_lane_nv_ff;
	logic lock_default_ff;
	logic [2:0] block_protect_nonvolatile_bits_ff;
	logic pend_dir_ff;
	logic pend_src_ff;
	logic pend_place_ff;
	logic pend_four_ff;
	logic [2:0] pend_bp_ff;
	logic [2:0] bp_v_ff;
	logic four_lane_v_ff;
	logic lock_ff;

	// Next value of each one-time bit: only a zero-to-one change is taken
	logic new_dir;
	logic new_src;
	logic new_place;
	logic new_four;
	logic [2:0] new_bp;
	logic cf1_nv_change;

	always_comb begin
		new_dir = prot_dir_ff;
		new_src = prot_src_ff;
		new_place = param_place_ff;
		new_four = four_lane_nv_ff;
		new_bp = block_protect_nonvolatile_bits_ff;
		if (wr_cf1_nv) begin
			// ones only, no error on zero
			// each bit taken on its own
			if (!lock_ff) begin
				new_dir = prot_dir_ff | cf1_data[flash_regs_pkg::CF1_PROT_DIR];
				new_src = prot_src_ff | cf1_data[flash_regs_pkg::CF1_PROT_SRC];
				new_place = param_place_ff
					| cf1_data[flash_regs_pkg::CF1_PARAM_PLACE];
			end
			new_four = cf1_data[flash_regs_pkg::CF1_FOUR_LANE]
				| (four_wire_protocol_v & four_lane_nv_ff);
		end
		if (wr_bp && !prot_src_ff && !lock_ff) begin
			new_bp = bp_data;
		end
		if (new_src && !prot_src_ff) begin
			new_bp = flash_regs_pkg::BP_ALL_SET;
		end
		cf1_nv_change = new_dir != prot_dir_ff || new_src != prot_src_ff
			|| new_place != param_place_ff || new_four != four_lane_nv_ff
			|| new_bp != block_protect_nonvolatile_bits_ff;
	end

	assign nv_start = state_ff == flash_regs_pkg::ST_IDLE
		&& (wr_cf1_nv || wr_bp) && cf1_nv_change;
	assign nv_done = state_ff == flash_regs_pkg::ST_NV_WRITE
		&& nv_cnt_ff == 16'(NV_CYCLES - 1);

	always_comb begin
		nxt_state = state_ff;
		unique case (state_ff)
			flash_regs_pkg::ST_IDLE: begin
				if (nv_start) begin
					nxt_state = flash_regs_pkg::ST_NV_WRITE;
				end
			end
			flash_regs_pkg::ST_NV_WRITE: begin
				if (nv_done) begin
					nxt_state = flash_regs_pkg::ST_IDLE;
				end
			end
			default: nxt_state = flash_regs_pkg::ST_IDLE;
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			state_ff <= flash_regs_pkg::ST_IDLE;
			nv_cnt_ff <= 16'h0000;
		end else begin
			state_ff <= nxt_state;
			nv_cnt_ff <= nv_start ? 16'h0000 : nv_cnt_ff + 16'h0001;
		end
	end

	// Pending values held for the whole program time
	always_ff @(posedge clk) begin
		if (rst) begin
			pend_dir_ff <= 1'b0;
			pend_src_ff <= 1'b0;
			pend_place_ff <= 1'b0;
			pend_four_ff <= 1'b0;
			pend_bp_ff <= flash_regs_pkg::BP_CLEAR;
		end else if (nv_start) begin
			pend_dir_ff <= new_dir;
			pend_src_ff <= new_src;
			pend_place_ff <= new_place;
			pend_four_ff <= new_four;
			pend_bp_ff <= new_bp;
		end
	end

	// rst stands for a factory-fresh power-on
	always_ff @(posedge clk) begin
		if (rst) begin
			prot_dir_ff <= 1'b0;
			prot_src_ff <= 1'b0;
			param_place_ff <= 1'b0;
			four_lane_nv_ff <= 1'b0;
			block_protect_nonvolatile_bits_ff <= flash_regs_pkg::BP_CLEAR;
		end else begin
			if (nv_done) begin
				prot_dir_ff <= pend_dir_ff;
				prot_src_ff <= pend_src_ff;
				param_place_ff <= pend_place_ff;
				four_lane_nv_ff <= pend_four_ff;
				block_protect_nonvolatile_bits_ff <= pend_bp_ff;
			end
			if (four_wire_protocol_nv_set) begin
				four_lane_nv_ff <= 1'b1;
			end
		end
	end

	// no write path to the lock default
	always_ff @(posedge clk) begin
		if (rst) begin
			lock_default_ff <= 1'b0;
		end else begin
			lock_default_ff <= lock_default_ff;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Volatile copies

	always_ff @(posedge clk) begin
		if (rst) begin
			bp_v_ff <= flash_regs_pkg::BP_CLEAR;
		end else if (soft_reset) begin
			bp_v_ff <= block_protect_nonvolatile_bits_ff;
		end else if (wr_bp && prot_src_ff && !lock_ff) begin
			bp_v_ff <= bp_data;
		end else if (nv_done) begin
			bp_v_ff <= pend_bp_ff;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			four_lane_v_ff <= 1'b0;
		end else if (soft_reset) begin
			four_lane_v_ff <= four_lane_nv_ff;
		end else if (wr_cf1_v) begin
			four_lane_v_ff <= cf1_data[flash_regs_pkg::CF1_FOUR_LANE]
				| (four_wire_protocol_v & four_lane_v_ff);
		end else if (nv_done) begin
			four_lane_v_ff <= pend_four_ff;
		end
	end

	// Lock survives command reset; only rst clears it
	always_ff @(posedge clk) begin
		if (rst) begin
			lock_ff <= lock_default_ff;
		end else if ((wr_cf1_v || (wr_cf1_nv && wrr_two))
			&& cf1_data[flash_regs_pkg::CF1_LOCK]) begin
			lock_ff <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Read images, frozen while a frame is running

	logic [7:0] cf1_nv_byte;
	logic [7:0] cf1_v_byte;
	always_comb begin
		cf1_nv_byte = flash_regs_pkg::RESET_BYTE;
		cf1_nv_byte[flash_regs_pkg::CF1_PROT_DIR] = prot_dir_ff;
		cf1_nv_byte[flash_regs_pkg::CF1_PROT_SRC] = prot_src_ff;
		cf1_nv_byte[flash_regs_pkg::CF1_PARAM_PLACE] = param_place_ff;
		cf1_nv_byte[flash_regs_pkg::CF1_FOUR_LANE] = four_lane_nv_ff;
		cf1_nv_byte[flash_regs_pkg::CF1_LOCK] = lock_default_ff;
		cf1_v_byte = cf1_nv_byte;
		cf1_v_byte[flash_regs_pkg::CF1_FOUR_LANE] = four_lane_v_ff;
		cf1_v_byte[flash_regs_pkg::CF1_LOCK] = lock_ff;
	end

	// Link reads image_ff unsynchronised; it only moves between frames
	always_ff @(posedge clk) begin
		if (rst) begin
			image_ff <= '0;
		end else if (cs_sync_ff) begin
			image_ff.status_two <= status_two;
			image_ff.config_one_nv <= cf1_nv_byte;
			image_ff.config_one_v <= cf1_v_byte;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs to the array protection and interface logic

	always_ff @(posedge clk) begin
		if (rst) begin
			protect_from_bottom <= 1'b0;
			param_block_at_top <= 1'b0;
			write_done <= 1'b0;
		end else begin
			protect_from_bottom <= prot_dir_ff;
			// one puts parameter block on top
			param_block_at_top <= param_place_ff && !uniform_sectors;
			write_done <= nv_done || (write_ok && (wr_cf1_v
				|| ((wr_cf1_nv || wr_bp) && !cf1_nv_change
				&& state_ff == flash_regs_pkg::ST_IDLE)));
		end
	end

	assign block_protect_bits = bp_v_ff;
	assign block_protect_nonvolatile_bits = block_protect_nonvolatile_bits_ff;
	assign four_lane_mode = four_lane_v_ff;
	assign protect_lock = lock_ff;
	assign nv_write_busy = state_ff == flash_regs_pkg::ST_NV_WRITE;

endmodule

// ---- src/flash_regs_pkg.sv ----
// Shared constants and types for the flash status and configuration block
package flash_regs_pkg;

	// Command opcodes
	localparam logic [7:0] OP_WRITE_REGISTERS = 8'h01;
	localparam logic [7:0] OP_READ_STATUS_TWO = 8'h07;
	localparam logic [7:0] OP_READ_ANY_REG = 8'h65;
	localparam logic [7:0] OP_WRITE_ANY_REG = 8'h71;

	// Register addresses for the any-register commands
	localparam logic [23:0] ADDR_STATUS_TWO_V = 24'h00_0007;
	localparam logic [23:0] ADDR_CONFIG_ONE_NV = 24'h00_0002;
	localparam logic [23:0] ADDR_CONFIG_ONE_V = 24'h00_0035;

	// Frame byte positions
	localparam int BYTE_OPCODE = 0;
	localparam int BYTE_ADDR_HI = 1;
	localparam int BYTE_ADDR_MID = 2;
	localparam int BYTE_ADDR_LO = 3;
	localparam int BYTE_WRITE_ANY_REGISTER_CMD_DATA = 4;
	localparam int FRAME_BYTES = 5;
	localparam logic [2:0] CNT_WRR_ONE = 3'h2;
	localparam logic [2:0] CNT_WRR_TWO = 3'h3;
	localparam logic [2:0] CNT_WRITE_ANY_REGISTER_CMD = 3'h5;
	localparam logic [2:0] CNT_READ_STATUS_TWO_CMD_DATA = 3'h1;
	localparam logic [2:0] CNT_READ_ANY_REGISTER_CMD_DATA = 3'h4;
	localparam logic [2:0] CNT_MAX = 3'h7;

	// Status two fields
	localparam int ST2_ERASE_RESULT = 2;
	localparam int ST2_ERASE_SUSP = 1;
	localparam int ST2_PROG_SUSP = 0;

	// Config one fields
	localparam int CF1_PROT_DIR = 5;
	localparam int CF1_PROT_SRC = 3;
	localparam int CF1_PARAM_PLACE = 2;
	localparam int CF1_FOUR_LANE = 1;
	localparam int CF1_LOCK = 0;

	// Status one block-protect field
	localparam int ST1_BP_LSB = 2;
	localparam int ST1_BP_MSB = 4;

	localparam logic [7:0] RESET_BYTE = 8'h00;
	localparam logic [2:0] BP_ALL_SET = 3'h7;
	localparam logic [2:0] BP_CLEAR = 3'h0;

	// Timing
	localparam int CLK_PERIOD_NS = 100;
	localparam int NV_WRITE_TIME_NS = 2000;
	localparam int NV_WRITE_CYCLES = (NV_WRITE_TIME_NS + CLK_PERIOD_NS - 1)
		/ CLK_PERIOD_NS;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_NV_WRITE = 2'b10
	} wr_state_t;

	// Register images the link side reads back
	typedef struct packed {
		logic [7:0] status_two;
		logic [7:0] config_one_nv;
		logic [7:0] config_one_v;
	} reg_image_t;

	// Suspend and erase-status inputs from the array controller
	typedef struct packed {
		logic erase_suspended;
		logic program_suspended;
		logic erase_status_strobe;
		logic erase_status_done;
	} array_status_t;

endpackage

// ---- bench/flash_regs_properties.sv ----
// Timing checks on the status-two and config-one register block
module flash_regs_properties #(
	parameter int NV_CYCLES = flash_regs_pkg::NV_WRITE_CYCLES
) (
	input logic clk,
	input logic rst,
	input logic sck,
	input logic cs_n,
	input logic si,
	input logic so,
	input logic so_oe_n,
	input flash_regs_pkg::array_status_t array_status,
	input logic write_enable,
	input logic four_wire_protocol_v,
	input logic four_wire_protocol_nv_set,
	input logic uniform_sectors,
	input logic soft_reset,
	input logic [2:0] block_protect_bits,
	input logic [2:0] block_protect_nonvolatile_bits,
	input logic protect_from_bottom,
	input logic param_block_at_top,
	input logic four_lane_mode,
	input logic protect_lock,
	input logic nv_write_busy,
	input logic write_done
);
	timeunit 1ns;
	timeprecision 1ps;
	int busy_cnt_ff;

	default clocking @(posedge clk); endclocking
	default disable iff (rst);

	// Length of the current program time
	always_ff @(posedge clk) begin
		if (rst || !nv_write_busy)
			busy_cnt_ff <= 0;
		else
			busy_cnt_ff <= busy_cnt_ff + 1;
	end

	////////////////////////////////////////////////////////////////////
	sequence s_done_soon;
		##[0:2] write_done;
	endsequence
	sequence s_held_idle;
		cs_n ##1 cs_n;
	endsequence

	property p_reset_clear;
		$fell(rst) |-> block_protect_bits == 3'h0 && !protect_lock
			&& block_protect_nonvolatile_bits == 3'h0
			&& !protect_from_bottom && !four_lane_mode && !nv_write_busy;
	endproperty
	property p_idle_quiet;
		s_held_idle |-> so_oe_n;
	endproperty
	property p_busy_len;
		$fell(nv_write_busy) |-> busy_cnt_ff >= NV_CYCLES
			&& busy_cnt_ff <= NV_CYCLES + 1;
	endproperty
	property p_done_pulse;
		write_done |=> !write_done;
	endproperty
	// Soft reset reloads; anything else must be a finished write
	property p_bp_cause;
		$changed(block_protect_bits) && !$past(soft_reset)
			&& !$past(soft_reset, 2) |-> s_done_soon;
	endproperty
	property p_lane_cause;
		$changed(four_lane_mode) && !$past(soft_reset)
			&& !$past(soft_reset, 2) |-> s_done_soon;
	endproperty
	property p_dir_sticky;
		protect_from_bottom |=> protect_from_bottom;
	endproperty
	property p_lock_sticky;
		protect_lock |=> protect_lock;
	endproperty
	property p_lane_held;
		four_wire_protocol_v && four_lane_mode && !soft_reset
			&& !$past(soft_reset) |=> four_lane_mode;
	endproperty
	property p_uniform;
		uniform_sectors |=> !param_block_at_top;
	endproperty

	a_reset_clear: assert property (p_reset_clear)
		else $error("outputs not clear after reset");
	a_idle_quiet: assert property (p_idle_quiet)
		else $error("data output driven outside a frame");
	a_busy_len: assert property (p_busy_len)
		else $error("program time length wrong");
	a_done_pulse: assert property (p_done_pulse)
		else $error("write done longer than one cycle");
	a_bp_cause: assert property (p_bp_cause)
		else $error("protection bits changed without a write");
	a_lane_cause: assert property (p_lane_cause)
		else $error("four-lane bit changed without a write");
	a_dir_sticky: assert property (p_dir_sticky)
		else $error("direction bit cleared");
	a_lock_sticky: assert property (p_lock_sticky)
		else $error("lock cleared without power-on");
	a_lane_held: assert property (p_lane_held)
		else $error("four-lane bit cleared under protocol bit");
	a_uniform: assert property (p_uniform)
		else $error("placement active in uniform layout");
endmodule

bind flash_status2_config1_regs flash_regs_properties #(
	.NV_CYCLES(NV_CYCLES)
) u_props (.clk, .rst, .sck, .cs_n, .si, .so, .so_oe_n, .array_status,
	.write_enable, .four_wire_protocol_v, .four_wire_protocol_nv_set,
	.uniform_sectors, .soft_reset, .block_protect_bits,
	.block_protect_nonvolatile_bits, .protect_from_bottom,
	.param_block_at_top, .four_lane_mode, .protect_lock, .nv_write_busy,
	.write_done);

// ---- bench/spi_host_model.sv ----
// Host serial controller model that frames commands on the link
module spi_host_model (
	output logic sck,
	output logic cs_n,
	output logic si,
	input logic so,
	input logic so_oe_n
);
	timeunit 1ns;
	timeprecision 1ps;

	initial begin
		sck = 1'b0;
		cs_n = 1'b0;
		si = 1'b0;
		// A real rising edge clears the link counters at power-up
		#5 cs_n = 1'b1;
	end

	task automatic xfer(input logic [7:0] q[$], output logic [7:0] rx);
		rx = 8'h00;
		#7 cs_n = 1'b0;
		foreach (q[j]) begin
			for (int i = 7; i >= 0; i--) begin
				si = q[j][i];
				#15 sck = 1'b1;
				// Undriven output must not pass as data
				rx = {rx[6:0], so_oe_n ? 1'bx : so};
				#15 sck = 1'b0;
			end
		end
		#15 cs_n = 1'b1;
		// Released line shows the inverse, not a stale bit
		si = ~si;
	endtask
endmodule

// ---- bench/testbench.sv ----
// Self-checking bench for the status-two and config-one registers
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin fail_count++; \
	$display("[ERR] %0t got %h exp %h", $time, a, b); end end
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0;
	logic rst = 1'b1;
	wire sck, cs_n, si, so, so_oe_n;
	flash_regs_pkg::array_status_t array_status = '0;
	logic write_enable = 1'b0;
	logic four_wire_protocol_v = 1'b0;
	logic four_wire_protocol_nv_set = 1'b0;
	logic uniform_sectors = 1'b0;
	logic soft_reset = 1'b0;
	logic [2:0] block_protect_bits, block_protect_nonvolatile_bits;
	logic protect_from_bottom, param_block_at_top, four_lane_mode;
	logic protect_lock, nv_write_busy, write_done;
	logic [7:0] d;
	logic saw_busy;
	int fail_count = 0;
	int checked = 0;

	always #50 clk = ~clk;

	flash_status2_config1_regs #(.NV_CYCLES(4)) DUT (.clk, .rst, .sck,
		.cs_n, .si, .so, .so_oe_n, .array_status, .write_enable,
		.four_wire_protocol_v, .four_wire_protocol_nv_set, .uniform_sectors,
		.soft_reset, .block_protect_bits, .block_protect_nonvolatile_bits,
		.protect_from_bottom, .param_block_at_top, .four_lane_mode,
		.protect_lock, .nv_write_busy, .write_done);
	spi_host_model host (.sck, .cs_n, .si, .so, .so_oe_n);

	////////////////////////////////////////////////////////////////////
	task automatic stop_test();
		$display("checked %0d fail_count %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic wait_done();
		int k;
		for (k = 0; k < 100; k++) begin
			tick(1);
			saw_busy |= nv_write_busy === 1'b1;
			if (write_done === 1'b1)
				break;
		end
		if (k == 100) begin
			fail_count++;
			stop_test();
		end
		tick(6);
	endtask
	// Writes without write_enable or to no writable register give no completion, so a fixed wait
	task automatic wr(input logic [7:0] q[$], input bit done_exp);
		host.xfer(q, d);
		if (done_exp)
			wait_done();
		else
			tick(20);
	endtask
	task automatic write_any_register_cmd(input logic [23:0] a, input logic [7:0] v);
		wr('{flash_regs_pkg::OP_WRITE_ANY_REG, a[23:16], a[15:8], a[7:0],
			v}, 1'b1);
	endtask
	task automatic rd(input logic [23:0] a, input logic [7:0] e);
		host.xfer('{flash_regs_pkg::OP_READ_ANY_REG, a[23:16], a[15:8],
			a[7:0], 8'h00}, d);
		tick(5);
		`CHK(d, e)
	endtask
	task automatic rd_st2(input logic [7:0] e);
		host.xfer('{flash_regs_pkg::OP_READ_STATUS_TWO, 8'h00}, d);
		tick(5);
		`CHK(d, e)
	endtask
	task automatic pulse_soft();
		soft_reset = 1'b1;
		tick(1);
		soft_reset = 1'b0;
		tick(4);
	endtask

	////////////////////////////////////////////////////////////////////
	task automatic t_reset();
		`CHK(block_protect_nonvolatile_bits, 3'h0)
		`CHK(so_oe_n, 1'b1)
		rd(flash_regs_pkg::ADDR_CONFIG_ONE_NV, 8'h00);
		rd_st2(8'h00);
		$display("test reset done");
	endtask
	task automatic t_status2();
		// erase status just before the read
		array_status = 4'b1111;
		tick(1);
		array_status.erase_status_strobe = 1'b0;
		tick(4);
		rd_st2(8'h07);
		write_enable = 1'b1;
		wr('{flash_regs_pkg::OP_WRITE_ANY_REG, 8'h00, 8'h00, 8'h07,
			8'hff}, 1'b0);
		rd(flash_regs_pkg::ADDR_STATUS_TWO_V, 8'h07);
		array_status = 4'b0010;
		tick(1);
		array_status = 4'b0000;
		tick(4);
		rd_st2(8'h00);
		$display("test status two done");
	endtask
	task automatic t_otp();
		write_enable = 1'b1;
		wr('{flash_regs_pkg::OP_WRITE_REGISTERS, 8'h00, 8'h20}, 1'b1);
		`CHK(protect_from_bottom, 1'b1)
		`CHK(param_block_at_top, 1'b0)
		wr('{flash_regs_pkg::OP_WRITE_REGISTERS, 8'h00, 8'h04}, 1'b1);
		`CHK(protect_from_bottom, 1'b1)
		`CHK(param_block_at_top, 1'b1)
		rd(flash_regs_pkg::ADDR_CONFIG_ONE_NV, 8'h24);
		uniform_sectors = 1'b1;
		tick(3);
		`CHK(param_block_at_top, 1'b0)
		uniform_sectors = 1'b0;
		$display("test one-time bits done");
	endtask
	task automatic t_protect();
		saw_busy = 1'b0;
		wr('{flash_regs_pkg::OP_WRITE_REGISTERS, 8'h14}, 1'b1);
		`CHK(saw_busy, 1'b1)
		`CHK(block_protect_nonvolatile_bits, 3'h5)
		`CHK(block_protect_bits, 3'h5)
		write_any_register_cmd(flash_regs_pkg::ADDR_CONFIG_ONE_NV, 8'h2c);
		`CHK(block_protect_nonvolatile_bits, 3'h7)
		pulse_soft();
		`CHK(block_protect_bits, 3'h7)
		saw_busy = 1'b0;
		wr('{flash_regs_pkg::OP_WRITE_REGISTERS, 8'h08}, 1'b1);
		`CHK(saw_busy, 1'b0)
		`CHK(block_protect_bits, 3'h2)
		`CHK(block_protect_nonvolatile_bits, 3'h7)
		write_enable = 1'b0;
		wr('{flash_regs_pkg::OP_WRITE_REGISTERS, 8'h1c}, 1'b0);
		`CHK(block_protect_bits, 3'h2)
		write_enable = 1'b1;
		$display("test protection done");
	endtask
	task automatic t_quad();
		write_any_register_cmd(flash_regs_pkg::ADDR_CONFIG_ONE_NV, 8'h2e);
		pulse_soft();
		`CHK(four_lane_mode, 1'b1)
		four_wire_protocol_v = 1'b1;
		wr('{flash_regs_pkg::OP_WRITE_ANY_REG, 8'h00, 8'h00, 8'h02,
			8'h2c}, 1'b0);
		rd(flash_regs_pkg::ADDR_CONFIG_ONE_NV, 8'h2e);
		four_wire_protocol_v = 1'b0;
		write_any_register_cmd(flash_regs_pkg::ADDR_CONFIG_ONE_NV, 8'h2c);
		pulse_soft();
		`CHK(four_lane_mode, 1'b0)
		four_wire_protocol_nv_set = 1'b1;
		tick(1);
		four_wire_protocol_nv_set = 1'b0;
		tick(4);
		rd(flash_regs_pkg::ADDR_CONFIG_ONE_NV, 8'h2e);
		$display("test four-lane done");
	endtask
	task automatic t_lock();
		write_any_register_cmd(flash_regs_pkg::ADDR_CONFIG_ONE_V, 8'h01);
		`CHK(protect_lock, 1'b1)
		pulse_soft();
		`CHK(protect_lock, 1'b1)
		write_any_register_cmd(flash_regs_pkg::ADDR_CONFIG_ONE_NV, 8'h2f);
		rd(flash_regs_pkg::ADDR_CONFIG_ONE_NV, 8'h2e);
		rst = 1'b1;
		tick(2);
		rst = 1'b0;
		tick(3);
		`CHK(protect_lock, 1'b0)
		`CHK(protect_from_bottom, 1'b0)
		$display("test lock and reset done");
	endtask

	initial begin
		repeat (10) @(posedge clk);
		#1;
		rst = 1'b0;
		tick(3);
		t_reset();
		t_status2();
		t_otp();
		t_protect();
		t_quad();
		t_lock();
		stop_test();
	end
endmodule
